// File: hw/serial_rx_cfg.svh
// Purpose: constants of the serial receive and spi clocking unit
// Assumes: one 200 MHz clock, oversample and spi half-period ticks come from outside
// Notes: included by bare name
`ifndef SERIAL_RX_CFG_SVH
`define SERIAL_RX_CFG_SVH
`define MODE_ASYNC 2'b00
`define MODE_SPI 2'b11
`define CHAR_NINE 3'b111
`define OS_NORMAL 5'd16
`define OS_DOUBLE 5'd8
`define CENTRE_NORMAL 5'd8
`define CENTRE_DOUBLE 5'd4
`define RX_DATA_BITS 9
`define RX_FIFO_DEPTH 2
`define SPI_BITS 4'd8
`define SPI_HALVES 5'd16
`define SPI_IDLE_FILL 8'hff
`define FE_POS 9
`define PE_POS 10
`define ENTRY_WIDTH 11
`endif

// File: hw/serial_rx_pkg.sv
// Purpose: types of the serial receive unit
// Assumes: nothing
// Notes: constants live in serial_rx_cfg.svh
package serial_rx_pkg;
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP = 5'b10000
  } rx_state_e;
endpackage

// File: hw/pin_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to sys_clk_i
// Notes: first stage read only by second stage
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// File: hw/rx_entry_fifo.sv
// Purpose: receive buffer holding data with its error flags per entry
// Assumes: push and pop may coincide; pop only when not empty
// Notes: depth must be a power of two, at least 2
`timescale 1ns/100ps
module rx_entry_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("rx_entry_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire do_push = push_i & (cnt_q != (AW+1)'(DEPTH) | pop_i);
  wire do_pop = pop_i & (cnt_q != '0);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        mem_q[wr_q] <= push_data_i;
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // flushed buffer shows zero contents
  assign head_o = (cnt_q == '0) ? '0 : mem_q[rd_q];
  assign full_o = (cnt_q == (AW+1)'(DEPTH));
  assign empty_o = (cnt_q == '0);
endmodule

// File: hw/serial_rx_unit.sv
// Purpose: uart receiver with two entry buffer, plus spi clock formats and transfer start
// Assumes: os_tick_i pulses at 16x or 8x baud, sck_tick_i at spi half-period rate
// Notes: transmit shifting of the uart and baud generation live elsewhere
`timescale 1ns/100ps
`include "serial_rx_cfg.svh"
module serial_rx_unit #(
  parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic os_tick_i,
  input wire logic sck_tick_i,
  input wire logic [1:0] operating_mode_field_i,
  input wire logic [2:0] char_size_field_i,
  input wire logic parity_enable_i,
  input wire logic parity_odd_i,
  input wire logic double_speed_select_i,
  input wire logic rx_enable_i,
  input wire logic tx_enable_i,
  input wire logic rx_complete_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic rx_read_i,
  input wire logic spi_master_select_i,
  input wire logic slave_select_output_enable_i,
  input wire logic clock_polarity_bit_i,
  input wire logic clock_phase_bit_i,
  input wire logic lsb_first_i,
  input wire logic tx_write_i,
  input wire logic [7:0] tx_data_i,
  input wire logic serial_rx_pin_i,
  input wire logic spi_master_out_line_i,
  input wire logic serial_clock_pin_i,
  input wire logic slave_select_pin_i,
  output logic spi_master_out_line_o,
  output logic spi_master_out_line_oe_o,
  output logic spi_master_in_line_o,
  output logic spi_master_in_line_oe_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  output logic slave_select_pin_o,
  output logic slave_select_pin_oe_o,
  output logic rx_pin_function_o,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_bit_o,
  output logic frame_error_flag_o,
  output logic overrun_flag_o,
  output logic parity_error_flag_o,
  output logic rx_complete_flag_o,
  output logic rx_irq_o,
  output logic tx_buffer_empty_flag_o
);
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("serial_rx_unit needs a receive buffer of at least 2 entries");
  end

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [3:0] char_bits(input logic [2:0] size);
    char_bits = (size == `CHAR_NINE) ? 4'd9 : 4'd5 + {2'b00, size[1:0]};
  endfunction

  function automatic logic [7:0] spi_shift(input logic [7:0] v, input logic lsb);
    spi_shift = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  function automatic logic spi_head(input logic [7:0] v, input logic lsb);
    spi_head = lsb ? v[0] : v[7];
  endfunction

  // pin synchronisers
  logic rx_s;
  logic mosi_s;
  logic sck_s;
  logic ss_s;

  pin_sync #(.WIDTH(4), .RESET_VAL(4'hf)) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pin_i({serial_rx_pin_i, spi_master_out_line_i, serial_clock_pin_i, slave_select_pin_i}),
    .sync_o({rx_s, mosi_s, sck_s, ss_s})
  );

  // mode decode
  wire async_mode = (operating_mode_field_i == `MODE_ASYNC);
  wire spi_mode = (operating_mode_field_i == `MODE_SPI);
  wire master = spi_mode & spi_master_select_i;
  wire [4:0] os_last = double_speed_select_i ? `OS_DOUBLE : `OS_NORMAL;
  wire [4:0] centre_first = double_speed_select_i ? `CENTRE_DOUBLE : `CENTRE_NORMAL;
  wire [4:0] centre_last = centre_first + 5'd2;
  wire [3:0] nbits = char_bits(char_size_field_i);

  // asynchronous receiver
  serial_rx_pkg::rx_state_e st_q;
  serial_rx_pkg::rx_state_e st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [1:0] vote_q;
  logic [3:0] bitn_q;
  logic [3:0] bitn_d;
  logic [8:0] sh_q;
  logic par_q;
  logic rx_prev_q;
  logic frame_done;

  wire [4:0] pos = cnt_q + 5'd1;
  wire in_centre = (pos >= centre_first) && (pos <= centre_last);
  wire decide = os_tick_i && (pos == centre_last);
  wire bit_end = os_tick_i && (pos == os_last);
  wire voted = maj3(vote_q[1], vote_q[0], rx_s);
  wire rx_run = rx_enable_i & async_mode;
  wire start_edge = os_tick_i & rx_prev_q & ~rx_s;
  wire [8:0] rx_aligned = sh_q >> (4'd9 - nbits);
  // parity over data bits, odd inverts
  wire par_ref = ^rx_aligned ^ parity_odd_i;
  wire par_bad = parity_enable_i & (par_ref != par_q);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bitn_d = bitn_q;
    frame_done = 1'b0;
    case (st_q)
      serial_rx_pkg::RX_IDLE: begin
        cnt_d = 5'd0;
        if (start_edge) begin
          st_d = serial_rx_pkg::RX_START;
          cnt_d = 5'd1;
        end
      end
      serial_rx_pkg::RX_START: begin
        if (os_tick_i) begin
          cnt_d = bit_end ? 5'd0 : pos;
        end
        if (decide && voted) begin
          st_d = serial_rx_pkg::RX_IDLE;
        end else if (bit_end) begin
          st_d = serial_rx_pkg::RX_DATA;
          bitn_d = 4'd0;
        end
      end
      serial_rx_pkg::RX_DATA: begin
        if (os_tick_i) begin
          cnt_d = bit_end ? 5'd0 : pos;
        end
        if (bit_end) begin
          bitn_d = bitn_q + 4'd1;
          if (bitn_q == nbits - 4'd1) begin
            st_d = parity_enable_i ? serial_rx_pkg::RX_PARITY : serial_rx_pkg::RX_STOP;
          end
        end
      end
      serial_rx_pkg::RX_PARITY: begin
        if (os_tick_i) begin
          cnt_d = bit_end ? 5'd0 : pos;
        end
        if (bit_end) begin
          st_d = serial_rx_pkg::RX_STOP;
        end
      end
      serial_rx_pkg::RX_STOP: begin
        if (os_tick_i) begin
          cnt_d = pos;
        end
        // first stop bit only, then idle
        if (decide) begin
          frame_done = 1'b1;
          st_d = serial_rx_pkg::RX_IDLE;
        end
      end
      default: begin
        st_d = serial_rx_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    // disable stops the receiver at once
    if (reset_i || !rx_run) begin
      st_q <= serial_rx_pkg::RX_IDLE;
      cnt_q <= 5'd0;
      bitn_q <= 4'd0;
      rx_prev_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bitn_q <= bitn_d;
      if (os_tick_i) begin
        rx_prev_q <= rx_s;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      vote_q <= 2'b11;
      sh_q <= 9'h000;
      par_q <= 1'b0;
    end else if (os_tick_i && in_centre) begin
      vote_q <= {vote_q[0], rx_s};
      // shift decided bit in arrival order
      if (decide && st_q == serial_rx_pkg::RX_DATA) begin
        sh_q <= {voted, sh_q[8:1]};
      end
      if (decide && st_q == serial_rx_pkg::RX_PARITY) begin
        par_q <= voted;
      end
    end
  end

  // spi engine
  logic ss_prev_q;
  logic sck_prev_q;
  logic lvl_q;
  logic mact_q;
  logic [4:0] half_q;
  logic [3:0] scnt_q;
  logic [7:0] rsh_q;
  logic [7:0] tsh_q;
  logic out_q;
  logic [7:0] hold_q;
  logic hold_full_q;

  wire ss_act = ~ss_s;
  // slave prepares first bit at select fall
  wire ss_fall = ss_prev_q & ~ss_s;
  wire sck_rise = ~sck_prev_q & sck_s;
  wire sck_fall = sck_prev_q & ~sck_s;
  wire slave_on = spi_mode & ~spi_master_select_i & ss_act;
  // leading edge leaves the idle level set by polarity
  wire lead_s = slave_on & (clock_polarity_bit_i ? sck_fall : sck_rise);
  wire trail_s = slave_on & (clock_polarity_bit_i ? sck_rise : sck_fall);
  wire lead_m = master & mact_q & sck_tick_i & ~lvl_q;
  wire trail_m = master & mact_q & sck_tick_i & lvl_q;
  wire lead = lead_m | lead_s;
  wire trail = trail_m | trail_s;
  // phase picks sample and shift edges
  wire samp = clock_phase_bit_i ? trail : lead;
  wire shft = clock_phase_bit_i ? lead : trail;
  wire spi_in = master ? rx_s : mosi_s;
  wire [7:0] rsh_next = lsb_first_i ? {spi_in, rsh_q[7:1]} : {rsh_q[6:0], spi_in};
  wire byte_done = samp & (scnt_q == `SPI_BITS - 4'd1);
  // master starts only from a written byte
  wire m_start = master & ~mact_q & hold_full_q;
  wire s_reload = slave_on & byte_done & clock_phase_bit_i;
  wire tx_load = m_start | (spi_mode & ~spi_master_select_i & ss_fall) | s_reload;
  wire [7:0] load_val = hold_full_q ? hold_q : `SPI_IDLE_FILL;
  wire spi_idle = ~spi_mode | (~spi_master_select_i & ss_s);
  wire hold_take = tx_write_i & (~hold_full_q | tx_load);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ss_prev_q <= 1'b1;
      sck_prev_q <= 1'b1;
    end else begin
      ss_prev_q <= ss_s;
      sck_prev_q <= sck_s;
    end
  end

  // master clock generation
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !master) begin
      lvl_q <= 1'b0;
      mact_q <= 1'b0;
      half_q <= 5'd0;
    end else if (m_start) begin
      mact_q <= 1'b1;
      lvl_q <= 1'b0;
      half_q <= 5'd0;
    end else if (mact_q && sck_tick_i) begin
      lvl_q <= ~lvl_q;
      half_q <= half_q + 5'd1;
      if (half_q == `SPI_HALVES - 5'd1) begin
        mact_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || spi_idle) begin
      scnt_q <= 4'd0;
      rsh_q <= 8'h00;
    end else if (samp) begin
      rsh_q <= rsh_next;
      scnt_q <= byte_done ? 4'd0 : scnt_q + 4'd1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tsh_q <= 8'h00;
      out_q <= 1'b1;
    end else if (tx_load) begin
      // phase 0 presents first bit on load
      if (!clock_phase_bit_i) begin
        out_q <= spi_head(load_val, lsb_first_i);
        tsh_q <= spi_shift(load_val, lsb_first_i);
      end else begin
        tsh_q <= load_val;
      end
    end else if (shft) begin
      // shift edge puts next bit out
      out_q <= spi_head(tsh_q, lsb_first_i);
      tsh_q <= spi_shift(tsh_q, lsb_first_i);
    end
  end

  // transmit holding byte
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else begin
      if (hold_take) begin
        hold_q <= tx_data_i;
      end
      hold_full_q <= hold_take | (hold_full_q & ~tx_load);
    end
  end

  // receive buffer
  logic [`ENTRY_WIDTH-1:0] head;
  logic fifo_full;
  logic fifo_empty;
  logic overrun_q;

  wire spi_push = byte_done & rx_enable_i;
  wire push_any = (frame_done & rx_run) | spi_push;
  wire pop = rx_read_i & ~fifo_empty;
  // full buffer at frame end loses the frame
  wire ovr_set = push_any & fifo_full & ~pop;
  wire push_ok = push_any & ~overrun_q & (~fifo_full | pop);
  wire [`ENTRY_WIDTH-1:0] entry = spi_push ? {3'b000, rsh_next} :
    {par_bad, ~voted, rx_aligned};

  rx_entry_fifo #(.WIDTH(`ENTRY_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .flush_i(~rx_enable_i),
    .push_i(push_ok),
    .push_data_i(entry),
    .pop_i(pop),
    .head_o(head),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !rx_enable_i) begin
      overrun_q <= 1'b0;
    end else if (ovr_set) begin
      overrun_q <= 1'b1;
    end else if (pop) begin
      overrun_q <= 1'b0;
    end
  end

  // status outputs
  assign rx_data_o = head[7:0];
  assign rx_ninth_bit_o = head[8];
  assign frame_error_flag_o = head[`FE_POS];
  assign parity_error_flag_o = head[`PE_POS] & parity_enable_i;
  assign overrun_flag_o = overrun_q;
  assign rx_complete_flag_o = ~fifo_empty;
  assign rx_irq_o = ~fifo_empty & rx_complete_irq_enable_i & global_irq_enable_i;
  assign rx_pin_function_o = rx_enable_i;
  assign tx_buffer_empty_flag_o = ~hold_full_q;

  // spi pin drive
  // polarity sets idle level
  assign serial_clock_pin_o = lvl_q ^ clock_polarity_bit_i;
  assign serial_clock_pin_oe_o = master;
  assign spi_master_out_line_o = out_q;
  assign spi_master_out_line_oe_o = master;
  assign spi_master_in_line_o = out_q;
  assign spi_master_in_line_oe_o = slave_on;
  assign slave_select_pin_o = ~mact_q;
  assign slave_select_pin_oe_o = master & ~slave_select_output_enable_i;
  // transmit enable does not gate the master clock
  wire unused_tx_enable = tx_enable_i;
endmodule

// File: dv/serial_rx_props.sv
// Purpose: port checks of the serial receive unit
// Assumes: one clock, sync active high reset
// Notes: bound by name after the module
`timescale 1ns/100ps
`include "serial_rx_cfg.svh"
module serial_rx_props (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [1:0] operating_mode_field_i,
  input wire logic parity_enable_i,
  input wire logic rx_enable_i,
  input wire logic rx_complete_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic rx_read_i,
  input wire logic spi_master_select_i,
  input wire logic slave_select_output_enable_i,
  input wire logic clock_polarity_bit_i,
  input wire logic tx_write_i,
  input wire logic serial_clock_pin_o,
  input wire logic slave_select_pin_o,
  input wire logic slave_select_pin_oe_o,
  input wire logic rx_pin_function_o,
  input wire logic [7:0] rx_data_o,
  input wire logic frame_error_flag_o,
  input wire logic overrun_flag_o,
  input wire logic parity_error_flag_o,
  input wire logic rx_complete_flag_o,
  input wire logic rx_irq_o,
  input wire logic tx_buffer_empty_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_flag_fall_cause: assert property ($fell(rx_complete_flag_o) |->
    $past(rx_read_i) || !$past(rx_enable_i)) else $error("flag fell without read");
  a_disable_flushes: assert property (!rx_enable_i |=>
    !rx_complete_flag_o && !overrun_flag_o) else $error("disable left data");
  a_pin_release: assert property (rx_pin_function_o == rx_enable_i)
    else $error("pin function wrong");
  a_irq_request: assert property (rx_irq_o == (rx_complete_flag_o &&
    rx_complete_irq_enable_i && global_irq_enable_i)) else $error("irq wrong");
  a_empty_no_data: assert property (!rx_complete_flag_o |->
    rx_data_o == 8'h00 && !frame_error_flag_o) else $error("data while empty");
  a_overrun_full: assert property ($rose(overrun_flag_o) |-> $past(rx_complete_flag_o))
    else $error("overrun without data");
  a_overrun_clear: assert property ($fell(overrun_flag_o) |->
    $past(rx_read_i) || !$past(rx_enable_i)) else $error("overrun fell alone");
  a_parity_off_zero: assert property (!parity_enable_i |-> !parity_error_flag_o)
    else $error("parity error while off");
  a_select_drive: assert property (slave_select_pin_oe_o |->
    operating_mode_field_i == `MODE_SPI && spi_master_select_i &&
    !slave_select_output_enable_i) else $error("select driven wrongly");
  a_idle_clock: assert property (slave_select_pin_o |->
    serial_clock_pin_o == clock_polarity_bit_i) else $error("clock idle level");
  a_tx_load: assert property (tx_write_i && tx_buffer_empty_flag_o |=>
    !tx_buffer_empty_flag_o) else $error("write not held");
  c_overrun: cover property ($rose(overrun_flag_o));
  c_frame_err: cover property ($rose(frame_error_flag_o));
  c_spi_run: cover property ($fell(slave_select_pin_o));
endmodule
bind serial_rx_unit serial_rx_props serial_rx_props_i (.*);

// File: dv/uart_tx_model.sv
// Purpose: remote uart transmitter sending prepared frames
// Assumes: one bit lasts tpb_i oversample ticks
// Notes: line idles high between frames
`timescale 1ns/100ps
module uart_tx_model (
  input wire logic sys_clk_i,
  input wire logic os_tick_i,
  input wire logic start_i,
  input wire logic [11:0] frame_i,
  input wire logic [3:0] nbits_i,
  input wire logic [4:0] tpb_i,
  output logic line_o,
  output logic busy_o
);
  logic [11:0] sh_q = 12'hfff;
  logic [3:0] left_q = 4'h0;
  logic [4:0] tick_q = 5'h00;
  assign busy_o = left_q != 4'h0;
  assign line_o = busy_o ? sh_q[0] : 1'b1;
  always_ff @(posedge sys_clk_i) begin
    if (start_i) begin
      sh_q <= frame_i;
      left_q <= nbits_i;
      tick_q <= 5'h00;
    end else if (busy_o && os_tick_i) begin
      if (tick_q == tpb_i - 5'h01) begin
        tick_q <= 5'h00;
        sh_q <= sh_q >> 1;
        left_q <= left_q - 4'h1;
      end else begin
        tick_q <= tick_q + 5'h01;
      end
    end
  end
endmodule

// File: dv/tb.sv
// Purpose: self-checking bench of the serial receive unit
// Assumes: tick every 4 cycles, 16 or 8 ticks per bit
// Notes: design ports joined by matching names
`timescale 1ns/100ps
`include "serial_rx_cfg.svh"
module tb;
  logic sys_clk_i, reset_i, os_tick_i, sck_tick_i, parity_enable_i, parity_odd_i;
  logic [1:0] operating_mode_field_i;
  logic [2:0] char_size_field_i;
  logic double_speed_select_i, rx_enable_i, tx_enable_i, rx_complete_irq_enable_i;
  logic global_irq_enable_i, rx_read_i, spi_master_select_i, slave_select_output_enable_i;
  logic clock_polarity_bit_i, clock_phase_bit_i, lsb_first_i, tx_write_i;
  logic [7:0] tx_data_i, rx_data_o;
  logic serial_rx_pin_i, spi_master_out_line_i, serial_clock_pin_i, slave_select_pin_i;
  logic spi_master_out_line_o, spi_master_out_line_oe_o, spi_master_in_line_o;
  logic spi_master_in_line_oe_o, serial_clock_pin_o, serial_clock_pin_oe_o;
  logic slave_select_pin_o, slave_select_pin_oe_o, rx_pin_function_o, rx_ninth_bit_o;
  logic frame_error_flag_o, overrun_flag_o, parity_error_flag_o, rx_complete_flag_o;
  logic rx_irq_o, tx_buffer_empty_flag_o, tx_start, tx_busy;
  logic [11:0] tx_frame;
  logic [3:0] tx_bits;
  logic [4:0] tx_tpb;
  logic [1:0] tcnt = 2'h0;
  logic sck_seen = 1'b1;
  logic [7:0] mosi_sh = 8'h00;
  int miscompares = 0;
  int tests_run = 0;

  serial_rx_unit serial_rx_unit_i (.*);
  uart_tx_model uart_tx_model_i (.sys_clk_i(sys_clk_i), .os_tick_i(os_tick_i),
    .start_i(tx_start), .frame_i(tx_frame), .nbits_i(tx_bits), .tpb_i(tx_tpb),
    .line_o(serial_rx_pin_i), .busy_o(tx_busy));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    tcnt <= tcnt + 2'h1;
    os_tick_i <= tcnt == 2'h3;
    sck_tick_i <= tcnt == 2'h1;
  end
  // collect master data out on the sampling edge of the pin clock
  always @(posedge sys_clk_i) begin
    sck_seen <= serial_clock_pin_o;
    if (sck_seen != serial_clock_pin_o &&
        serial_clock_pin_o == (clock_phase_bit_i ^ ~clock_polarity_bit_i)) begin
      mosi_sh <= lsb_first_i ? {spi_master_out_line_o, mosi_sh[7:1]} :
        {mosi_sh[6:0], spi_master_out_line_o};
    end
  end

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic pen,
      input logic bad_par, input logic stop);
    logic [11:0] f;
    logic p;
    int k;
    #1;
    p = parity_odd_i ^ bad_par;
    f = 12'hfff;
    f[0] = 1'b0;
    k = 1;
    for (int i = 0; i < nb; i++) begin
      f[k] = d[i];
      p ^= d[i];
      k++;
    end
    if (pen) begin
      f[k] = p;
      k++;
    end
    f[k] = stop;
    @(posedge sys_clk_i);
    tx_frame <= f;
    tx_bits <= 4'(k + 1);
    tx_start <= 1'b1;
    @(posedge sys_clk_i) tx_start <= 1'b0;
    cyc(1);
    for (int w = 0; w < 2000 && tx_busy; w++) @(posedge sys_clk_i);
    cyc(8);
  endtask
  task automatic rd(input logic [8:0] d, input logic fe, input logic pe);
    chk("flag", rx_complete_flag_o, 9'h1);
    chk("frame_err", frame_error_flag_o, fe);
    chk("parity_err", parity_error_flag_o, pe);
    chk("data", {rx_ninth_bit_o, rx_data_o}, d);
    @(posedge sys_clk_i) rx_read_i <= 1'b1;
    @(posedge sys_clk_i) rx_read_i <= 1'b0;
    cyc(1);
  endtask
  task automatic spi_byte(input logic [7:0] b);
    @(posedge sys_clk_i) tx_write_i <= 1'b1;
    tx_data_i <= b;
    @(posedge sys_clk_i) tx_write_i <= 1'b0;
    for (int w = 0; w < 100 && slave_select_pin_o; w++) cyc(1);
    chk("ss_active", slave_select_pin_o, 9'h0);
    for (int w = 0; w < 400 && !slave_select_pin_o; w++) cyc(1);
    chk("ss_high", slave_select_pin_o, 9'h1);
    cyc(4);
    chk("sck_idle", serial_clock_pin_o, 9'h1);
    chk("mosi", {1'b0, mosi_sh}, {1'b0, b});
    rd(9'h0ff, 1'b0, 1'b0);
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk_i);
    miscompares++;
    test_done();
  end

  initial begin
    {reset_i, parity_enable_i, parity_odd_i} = 3'h4;
    {double_speed_select_i, tx_enable_i, global_irq_enable_i, rx_read_i} = 4'h0;
    {spi_master_select_i, slave_select_output_enable_i, clock_polarity_bit_i} = 3'h0;
    {clock_phase_bit_i, lsb_first_i, tx_write_i, tx_start} = 4'h0;
    {rx_enable_i, rx_complete_irq_enable_i} = 2'h3;
    {spi_master_out_line_i, serial_clock_pin_i, slave_select_pin_i} = 3'h7;
    operating_mode_field_i = `MODE_ASYNC;
    char_size_field_i = 3'h3;
    tx_data_i = 8'h00;
    tx_frame = 12'hfff;
    tx_bits = 4'h0;
    tx_tpb = 5'd16;
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    cyc(3);
    chk("tx_empty", tx_buffer_empty_flag_o, 9'h1);
    chk("flag", rx_complete_flag_o, 9'h0);
    fin("reset");
    send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
    chk("irq", rx_irq_o, 9'h0);
    @(posedge sys_clk_i) global_irq_enable_i <= 1'b1;
    cyc(1);
    chk("irq", rx_irq_o, 9'h1);
    rd(9'h0a5, 1'b0, 1'b0);
    chk("irq", rx_irq_o, 9'h0);
    chk("flag", rx_complete_flag_o, 9'h0);
    fin("basic");
    @(posedge sys_clk_i) parity_enable_i <= 1'b1;
    send(9'h007, 8, 1'b1, 1'b0, 1'b1);
    send(9'h007, 8, 1'b1, 1'b1, 1'b1);
    rd(9'h007, 1'b0, 1'b0);
    rd(9'h007, 1'b0, 1'b1);
    @(posedge sys_clk_i) parity_odd_i <= 1'b1;
    send(9'h0c3, 8, 1'b1, 1'b0, 1'b1);
    rd(9'h0c3, 1'b0, 1'b0);
    @(posedge sys_clk_i) {parity_enable_i, parity_odd_i} <= 2'h0;
    fin("parity");
    send(9'h011, 8, 1'b0, 1'b0, 1'b1);
    send(9'h022, 8, 1'b0, 1'b0, 1'b0);
    send(9'h033, 8, 1'b0, 1'b0, 1'b1);
    chk("overrun", overrun_flag_o, 9'h1);
    rd(9'h011, 1'b0, 1'b0);
    chk("overrun", overrun_flag_o, 9'h0);
    rd(9'h022, 1'b1, 1'b0);
    chk("flag", rx_complete_flag_o, 9'h0);
    fin("overrun");
    send(9'h05a, 8, 1'b0, 1'b0, 1'b1);
    @(posedge sys_clk_i) rx_enable_i <= 1'b0;
    cyc(2);
    chk("flag", rx_complete_flag_o, 9'h0);
    chk("pin_fn", rx_pin_function_o, 9'h0);
    @(posedge sys_clk_i) rx_enable_i <= 1'b1;
    cyc(2);
    chk("flag", rx_complete_flag_o, 9'h0);
    fin("flush");
    @(posedge sys_clk_i) char_size_field_i <= `CHAR_NINE;
    send(9'h1a5, 9, 1'b0, 1'b0, 1'b1);
    rd(9'h1a5, 1'b0, 1'b0);
    @(posedge sys_clk_i) char_size_field_i <= 3'h3;
    double_speed_select_i <= 1'b1;
    tx_tpb <= 5'd8;
    send(9'h03c, 8, 1'b0, 1'b0, 1'b1);
    rd(9'h03c, 1'b0, 1'b0);
    fin("nine_and_double");
    @(posedge sys_clk_i) operating_mode_field_i <= `MODE_SPI;
    {spi_master_select_i, clock_polarity_bit_i, lsb_first_i} <= 3'h7;
    cyc(3);
    chk("sck_idle", serial_clock_pin_o, 9'h1);
    chk("ss_oe", slave_select_pin_oe_o, 9'h1);
    chk("sck_oe", serial_clock_pin_oe_o, 9'h1);
    chk("mosi_oe", spi_master_out_line_oe_o, 9'h1);
    chk("miso_oe", spi_master_in_line_oe_o, 9'h0);
    spi_byte(8'h5a);
    @(posedge sys_clk_i) {clock_phase_bit_i, lsb_first_i} <= 2'h2;
    spi_byte(8'hc3);
    fin("spi");
    test_done();
  end
endmodule
